// ---- src/qu_pkg.sv ----
package qu_pkg;

  // ---------------------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------------------
  localparam int unsigned CHANNELS = 4;
  localparam int unsigned REGS = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned REG_SEL_W = 3;
  localparam int unsigned CH_SEL_W = 2;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned CH_SEL_LSB = 3;

  // ---------------------------------------------------------------------------
  // Register indexes inside one channel
  // ---------------------------------------------------------------------------
  localparam logic [REG_SEL_W-1:0] IDX_INT_EN = 3'h1;
  localparam logic [REG_SEL_W-1:0] IDX_ISR = 3'h2;
  localparam logic [REG_SEL_W-1:0] IDX_MODEM_CTL = 3'h4;
  localparam logic [REG_SEL_W-1:0] IDX_MSR = 3'h6;

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int unsigned MODEM_CTL_OE_BIT = 3;
  localparam int unsigned MSR_RING_EDGE_BIT = 2;
  localparam int unsigned MSR_RING_LVL_BIT = 6;
  localparam int unsigned INT_EN_W = 4;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

  // Bus style straps: per-channel selects versus one shared select.
  localparam logic STYLE_PER_CHANNEL = 1'b1;
  localparam logic STYLE_SHARED = 1'b0;

  // ---------------------------------------------------------------------------
  // Interrupt condition bundle; bit order matches the enable register.
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic modem_change;
    logic rx_error;
    logic tx_empty;
    logic rx_data;
  } qu_cond_type;

  typedef logic [DATA_W-1:0] qu_byte_type;

endpackage

// ---- src/qu_host_port.sv ----
// Overview of operation
// - Per-channel style: interrupt pin high only with enable, condition, and modem-control bit 3 or interrupt select high.
// - Receiver error, received data, transmit empty, modem change are interrupt conditions.
// - Interrupt select high keeps interrupt pins always enabled, ignoring modem-control bit 3.
// - Interrupt select low floats each interrupt pin unless its modem-control bit 3 set.
// - Interrupt select defaults low when undriven; ignored in shared style.
// - Per-channel style: read strobe falling edge drives addressed register onto data bus.
// - Per-channel style: write strobe falling edge stores data bus into addressed register.
// - Shared style: all channel interrupts ORed into one active-low request.
// - Shared style: host finds interrupting channel by reading each channel's status.
// - Per-channel style: the shared request pin serves as channel A interrupt.
// - Per-channel style: reset pin high clears all registers and outputs except uart_reset_out, which it drives high.
// - During reset the serial transmitter is disabled and receive input ignored.
// - Shared style: the reset pin is active low, otherwise identical.
// - Call-alert low means ringing; its rise to high raises an interrupt condition.
// - Shared style: read/write strobe high reads, low writes, addressed by select and five bits.
// - Shared style: one active-low select enables all, upper two address bits pick channel.
// - Per-channel style: a channel is addressed by driving its own select low.
module qu_host_port (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic bus_style_in,
  input wire logic reset_pin_in,
  input wire logic interrupt_output_select_in,
  input wire logic [qu_pkg::CHANNELS-1:0] per_channel_select_n_in,
  input wire logic [qu_pkg::ADDR_W-1:0] register_select_bits_in,
  input wire logic host_read_strobe_n_in,
  input wire logic host_write_strobe_n_in,
  input wire qu_pkg::qu_byte_type host_data_bus_in,
  output qu_pkg::qu_byte_type host_data_bus_out,
  output logic host_data_bus_oe_out,
  input wire qu_pkg::qu_cond_type [qu_pkg::CHANNELS-1:0] cond_in,
  input wire logic [qu_pkg::CHANNELS-1:0] call_alert_in,
  output logic [qu_pkg::CHANNELS-1:0] channel_interrupt_out,
  output logic [qu_pkg::CHANNELS-1:0] channel_interrupt_oe_out,
  output logic [qu_pkg::CHANNELS-1:0] serial_enable_out,
  output logic uart_reset_out
);

  // ---------------------------------------------------------------------------
  // Reset pin and bus style decode
  // ---------------------------------------------------------------------------
  logic per_mode;
  logic uart_rst;
  logic int_sel_eff;

  assign per_mode = (bus_style_in == qu_pkg::STYLE_PER_CHANNEL);
  // The pin polarity flips with the bus style; the action is the same.
  assign uart_rst = per_mode ? reset_pin_in : ~reset_pin_in;
  // The pad pull-down is modelled as a low input; shared style drops the pin.
  assign int_sel_eff = per_mode & interrupt_output_select_in;

  // ---------------------------------------------------------------------------
  // Channel and register selection
  // ---------------------------------------------------------------------------
  logic [qu_pkg::CH_SEL_W-1:0] ch_sel;
  logic ch_hit;
  logic [qu_pkg::REG_SEL_W-1:0] reg_sel;

  assign reg_sel = register_select_bits_in[qu_pkg::REG_SEL_W-1:0];

  // Two selects low at once is a host fault; the lowest channel wins then.
  always_comb begin
    ch_sel = '0;
    ch_hit = 1'b0;
    if (per_mode) begin
      for (int i = qu_pkg::CHANNELS - 1; i >= 0; i--) begin
        if (!per_channel_select_n_in[i]) begin
          ch_sel = qu_pkg::CH_SEL_W'(i);
          ch_hit = 1'b1;
        end
      end
    end else begin
      ch_sel = register_select_bits_in[qu_pkg::ADDR_W-1:qu_pkg::CH_SEL_LSB];
      ch_hit = ~per_channel_select_n_in[0];
    end
  end

  // ---------------------------------------------------------------------------
  // Strobe edge detection
  // ---------------------------------------------------------------------------
  logic rd_n_prev_reg;
  logic wr_n_prev_reg;
  logic cs_n_prev_reg;
  logic rd_take;
  logic wr_take;
  logic rd_active;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_n_prev_reg <= 1'b1;
      wr_n_prev_reg <= 1'b1;
      cs_n_prev_reg <= 1'b1;
    end else begin
      rd_n_prev_reg <= host_read_strobe_n_in;
      wr_n_prev_reg <= host_write_strobe_n_in;
      cs_n_prev_reg <= per_channel_select_n_in[0];
    end
  end

  // In shared style the write strobe pin carries read/write and the select edge times it.
  always_comb begin
    if (per_mode) begin
      rd_take = rd_n_prev_reg & ~host_read_strobe_n_in & ch_hit;
      wr_take = wr_n_prev_reg & ~host_write_strobe_n_in & ch_hit;
      rd_active = ~host_read_strobe_n_in & ch_hit;
    end else begin
      rd_take = cs_n_prev_reg & ch_hit & host_write_strobe_n_in;
      wr_take = cs_n_prev_reg & ch_hit & ~host_write_strobe_n_in;
      rd_active = ch_hit & host_write_strobe_n_in;
    end
  end

  // ---------------------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------------------
  qu_pkg::qu_byte_type regs_reg [qu_pkg::CHANNELS][qu_pkg::REGS];

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int c = 0; c < qu_pkg::CHANNELS; c++) begin
        for (int r = 0; r < qu_pkg::REGS; r++) begin
          regs_reg[c][r] <= qu_pkg::REG_RESET;
        end
      end
    end else if (uart_rst) begin
      for (int c = 0; c < qu_pkg::CHANNELS; c++) begin
        for (int r = 0; r < qu_pkg::REGS; r++) begin
          regs_reg[c][r] <= qu_pkg::REG_RESET;
        end
      end
    end else if (wr_take) begin
      regs_reg[ch_sel][reg_sel] <= host_data_bus_in;
    end
  end

  // ---------------------------------------------------------------------------
  // Ring detection and pending conditions
  // ---------------------------------------------------------------------------
  logic [qu_pkg::CHANNELS-1:0] alert_prev_reg;
  logic [qu_pkg::CHANNELS-1:0] ring_flag_reg;
  logic [qu_pkg::CHANNELS-1:0] ring_rise;
  logic [qu_pkg::CHANNELS-1:0] msr_read;
  logic [qu_pkg::CHANNELS-1:0] pend;
  qu_pkg::qu_cond_type [qu_pkg::CHANNELS-1:0] cond_eff;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      alert_prev_reg <= '1;
    end else begin
      alert_prev_reg <= call_alert_in;
    end
  end

  always_comb begin
    for (int c = 0; c < qu_pkg::CHANNELS; c++) begin
      ring_rise[c] = ~alert_prev_reg[c] & call_alert_in[c] & ~uart_rst;
      msr_read[c] = rd_take & (ch_sel == qu_pkg::CH_SEL_W'(c)) & (reg_sel == qu_pkg::IDX_MSR);
      cond_eff[c] = uart_rst ? '0 : cond_in[c];
      cond_eff[c].modem_change = ~uart_rst & (cond_in[c].modem_change | ring_flag_reg[c]);
      pend[c] = |(regs_reg[c][qu_pkg::IDX_INT_EN][qu_pkg::INT_EN_W-1:0] & cond_eff[c]);
    end
  end

  // A ring edge landing on the same cycle as the status read stays pending.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ring_flag_reg <= '0;
    end else if (uart_rst) begin
      ring_flag_reg <= '0;
    end else begin
      ring_flag_reg <= ring_rise | (ring_flag_reg & ~msr_read);
    end
  end

  // ---------------------------------------------------------------------------
  // Read data path
  // ---------------------------------------------------------------------------
  qu_pkg::qu_byte_type rd_data;

  always_comb begin
    rd_data = regs_reg[ch_sel][reg_sel];
    if (reg_sel == qu_pkg::IDX_ISR) begin
      rd_data = {{(qu_pkg::DATA_W - qu_pkg::INT_EN_W){1'b0}}, cond_eff[ch_sel]};
    end else if (reg_sel == qu_pkg::IDX_MSR) begin
      rd_data = '0;
      rd_data[qu_pkg::MSR_RING_EDGE_BIT] = ring_flag_reg[ch_sel];
      rd_data[qu_pkg::MSR_RING_LVL_BIT] = ~call_alert_in[ch_sel];
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      host_data_bus_out <= '0;
    end else if (uart_rst) begin
      host_data_bus_out <= '0;
    end else if (rd_take) begin
      host_data_bus_out <= rd_data;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      host_data_bus_oe_out <= 1'b0;
    end else begin
      host_data_bus_oe_out <= ~uart_rst & (rd_take | (host_data_bus_oe_out & rd_active));
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt pins
  // ---------------------------------------------------------------------------
  // Registered once so every pin comes from a flop; that costs exactly one cycle.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      channel_interrupt_out <= '0;
      channel_interrupt_oe_out <= '0;
    end else if (uart_rst) begin
      channel_interrupt_out <= '0;
      channel_interrupt_oe_out <= '0;
    end else if (per_mode) begin
      for (int c = 0; c < qu_pkg::CHANNELS; c++) begin
        // Channel A shares its pin with the shared-style request.
        channel_interrupt_oe_out[c] <=
          int_sel_eff | regs_reg[c][qu_pkg::IDX_MODEM_CTL][qu_pkg::MODEM_CTL_OE_BIT];
        channel_interrupt_out[c] <= pend[c] &
          (int_sel_eff | regs_reg[c][qu_pkg::IDX_MODEM_CTL][qu_pkg::MODEM_CTL_OE_BIT]);
      end
    end else begin
      // Open-drain request: pulls low when any enabled channel waits, else floats.
      channel_interrupt_out <= '0;
      channel_interrupt_oe_out <= '0;
      channel_interrupt_oe_out[0] <= |pend;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      serial_enable_out <= '0;
      uart_reset_out <= 1'b1;
    end else begin
      serial_enable_out <= {qu_pkg::CHANNELS{~uart_rst}};
      uart_reset_out <= uart_rst;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  property p_int_needs_cause;
    @(posedge clk_in) disable iff (!arst_n_in)
      ##1 (per_mode && $past(per_mode) && channel_interrupt_out[1]) |->
        $past(pend[1]) && $past(int_sel_eff | regs_reg[1][qu_pkg::IDX_MODEM_CTL][qu_pkg::MODEM_CTL_OE_BIT]);
  endproperty
  a_int_needs_cause: assert property (p_int_needs_cause) else $error("interrupt pin high without cause");

  property p_sel_forces_oe;
    @(posedge clk_in) disable iff (!arst_n_in)
      (per_mode && interrupt_output_select_in && !uart_rst) |=> (&channel_interrupt_oe_out);
  endproperty
  a_sel_forces_oe: assert property (p_sel_forces_oe) else $error("interrupt pins not enabled by select");

  property p_ctl_bit_floats;
    @(posedge clk_in) disable iff (!arst_n_in)
      (per_mode && !interrupt_output_select_in && !regs_reg[2][qu_pkg::IDX_MODEM_CTL][qu_pkg::MODEM_CTL_OE_BIT])
        |=> !channel_interrupt_oe_out[2];
  endproperty
  a_ctl_bit_floats: assert property (p_ctl_bit_floats)
    else $error("interrupt pin driven without its output enable bit");

  property p_shared_request;
    @(posedge clk_in) disable iff (!arst_n_in)
      (!per_mode && !uart_rst) |=> (channel_interrupt_oe_out[0] == $past(|pend)) && !channel_interrupt_out[0];
  endproperty
  a_shared_request: assert property (p_shared_request)
    else $error("shared request does not follow pending");

  property p_read_drives;
    @(posedge clk_in) disable iff (!arst_n_in)
      (rd_take && !uart_rst) |=> host_data_bus_oe_out && (host_data_bus_out == $past(rd_data));
  endproperty
  a_read_drives: assert property (p_read_drives) else $error("read strobe did not drive data");

  property p_write_stores;
    @(posedge clk_in) disable iff (!arst_n_in)
      (wr_take && !uart_rst && per_mode && reg_sel == qu_pkg::IDX_INT_EN && ch_sel == 2'h0)
        |=> regs_reg[0][qu_pkg::IDX_INT_EN] == $past(host_data_bus_in);
  endproperty
  a_write_stores: assert property (p_write_stores) else $error("write strobe did not store data");

  property p_reset_quiet;
    @(posedge clk_in) disable iff (!arst_n_in)
      uart_rst |=> !host_data_bus_oe_out && (channel_interrupt_oe_out == '0) && (serial_enable_out == '0);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active during reset");

  property p_shared_reset_low;
    @(posedge clk_in) disable iff (!arst_n_in)
      (!per_mode && !reset_pin_in) |=> uart_reset_out && (regs_reg[3][qu_pkg::IDX_MODEM_CTL] == qu_pkg::REG_RESET);
  endproperty
  a_shared_reset_low: assert property (p_shared_reset_low) else $error("active-low reset not honoured");

  property p_ring_sets;
    @(posedge clk_in) disable iff (!arst_n_in)
      ring_rise[3] |=> ring_flag_reg[3];
  endproperty
  a_ring_sets: assert property (p_ring_sets) else $error("ring rise not latched");

  property p_ring_holds;
    @(posedge clk_in) disable iff (!arst_n_in)
      (ring_flag_reg[3] && !msr_read[3] && !uart_rst) |=> ring_flag_reg[3];
  endproperty
  a_ring_holds: assert property (p_ring_holds) else $error("ring flag lost without status read");

endmodule

// ---- tb/qu_host_model.sv ----
module qu_host_model (
  input wire logic clk_in,
  input wire logic bus_style_in,
  input wire qu_pkg::qu_byte_type bus_in,
  input wire logic bus_oe_in,
  output logic [qu_pkg::CHANNELS-1:0] select_n_out,
  output logic [qu_pkg::ADDR_W-1:0] address_out,
  output logic read_n_out,
  output logic write_n_out,
  output qu_pkg::qu_byte_type wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    select_n_out = '1;
    address_out = 5'h00;
    read_n_out = 1'b1;
    write_n_out = 1'b1;
    wdata_out = 8'h00;
  end

  // ---------------------------------------------------------------------------
  // Single byte access
  // ---------------------------------------------------------------------------
  // A read is held until the data enable is seen; a write is held over the edge
  // that takes it. One idle edge follows, so the next strobe is a fresh fall.
  task automatic access(input logic [1:0] ch, input logic [2:0] idx, input logic is_read,
                        input qu_pkg::qu_byte_type wdata, output qu_pkg::qu_byte_type rdata,
                        output logic ok);
    int n;
    n = 0;
    @(posedge clk_in);
    address_out <= {ch, idx};
    wdata_out <= wdata;
    write_n_out <= is_read;
    if (bus_style_in == qu_pkg::STYLE_PER_CHANNEL) begin
      select_n_out[ch] <= 1'b0;
      read_n_out <= !is_read;
    end else begin
      select_n_out[0] <= 1'b0;
    end
    do begin
      @(posedge clk_in);
      n++;
    end while (n < 8 && (is_read ? bus_oe_in !== 1'b1 : n < 2));
    rdata = bus_in;
    ok = !is_read || bus_oe_in === 1'b1;
    select_n_out <= '1;
    read_n_out <= 1'b1;
    write_n_out <= 1'b1;
    // A released bus must not keep showing the last byte.
    wdata_out <= ~wdata;
    @(posedge clk_in);
  endtask
endmodule

// ---- tb/quad_uart_host_bus_and_irq_tb_top.sv ----
module quad_uart_host_bus_and_irq_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic bus_style_in = qu_pkg::STYLE_PER_CHANNEL;
  logic reset_pin_in = 1'b0;
  logic int_sel = 1'b0;
  qu_pkg::qu_cond_type [3:0] cond = '0;
  logic [3:0] ring_n = 4'hf;
  logic [3:0] sel_n;
  logic [4:0] addr;
  logic rd_n;
  logic wr_n;
  logic dout_oe;
  logic ureset;
  logic irq_n;
  logic [3:0] int_out;
  logic [3:0] int_oe;
  logic [3:0] ser_en;
  qu_pkg::qu_byte_type host_wdata;
  qu_pkg::qu_byte_type dout;
  qu_pkg::qu_byte_type bus_wire;
  int fail_count = 0;
  int n_tests = 0;

  always #20 clk_in = ~clk_in;
  assign bus_wire = dout_oe ? dout : host_wdata;
  // The shared request is open drain with a pull-up.
  assign irq_n = int_oe[0] ? 1'b0 : 1'b1;

  qu_host_port u_qu_host_port (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .bus_style_in(bus_style_in),
    .reset_pin_in(reset_pin_in),
    .interrupt_output_select_in(int_sel),
    .per_channel_select_n_in(sel_n),
    .register_select_bits_in(addr),
    .host_read_strobe_n_in(rd_n),
    .host_write_strobe_n_in(wr_n),
    .host_data_bus_in(bus_wire),
    .host_data_bus_out(dout),
    .host_data_bus_oe_out(dout_oe),
    .cond_in(cond),
    .call_alert_in(ring_n),
    .channel_interrupt_out(int_out),
    .channel_interrupt_oe_out(int_oe),
    .serial_enable_out(ser_en),
    .uart_reset_out(ureset)
  );

  qu_host_model u_qu_host_model (
    .clk_in(clk_in),
    .bus_style_in(bus_style_in),
    .bus_in(bus_wire),
    .bus_oe_in(dout_oe),
    .select_n_out(sel_n),
    .address_out(addr),
    .read_n_out(rd_n),
    .write_n_out(wr_n),
    .wdata_out(host_wdata)
  );

  // ---------------------------------------------------------------------------
  // Access and compare tasks
  // ---------------------------------------------------------------------------
  task automatic conclude();
    if (fail_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input int c, input logic [2:0] idx, input logic is_read, input logic [7:0] d,
                      output logic [7:0] r);
    logic ok;
    u_qu_host_model.access(2'(c), idx, is_read, d, r, ok);
    if (ok !== 1'b1) begin
      fail_count++;
      conclude();
    end
  endtask

  task automatic wr(input int c, input logic [2:0] idx, input logic [7:0] d);
    logic [7:0] r;
    xfer(c, idx, 1'b0, d, r);
  endtask

  task automatic rd_chk(input int c, input logic [2:0] idx, input logic [7:0] exp);
    logic [7:0] r;
    xfer(c, idx, 1'b1, 8'h00, r);
    check(r, exp);
  endtask

  task automatic int_chk(input logic [3:0] exp_oe, input logic [3:0] exp_out);
    repeat (3) @(posedge clk_in);
    check({4'h0, int_oe}, {4'h0, exp_oe});
    check({4'h0, int_out}, {4'h0, exp_out});
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_in);
    check({7'h0, ureset}, 8'h01);
    check({4'h0, ser_en}, 8'h00);
    arst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    check({4'h0, ser_en}, 8'h0f);
    check({7'h0, ureset}, 8'h00);
    for (int c = 0; c < 4; c++) wr(c, 3'h3, 8'h5a ^ 8'(c));
    for (int c = 0; c < 4; c++) rd_chk(c, 3'h3, 8'h5a ^ 8'(c));
    for (int b = 0; b < 4; b++) begin
      cond[0] <= qu_pkg::qu_cond_type'(4'(1 << b));
      wr(0, qu_pkg::IDX_INT_EN, 8'(1 << b));
      wr(0, qu_pkg::IDX_MODEM_CTL, 8'h00);
      int_chk(4'h0, 4'h0);
      wr(0, qu_pkg::IDX_MODEM_CTL, 8'h08);
      int_chk(4'h1, 4'h1);
      wr(0, qu_pkg::IDX_INT_EN, 8'(~(1 << b)) & 8'h0f);
      int_chk(4'h1, 4'h0);
    end
    for (int c = 1; c < 4; c++) begin
      cond[c] <= qu_pkg::qu_cond_type'(4'h1);
      wr(c, qu_pkg::IDX_INT_EN, 8'h01);
      wr(c, qu_pkg::IDX_MODEM_CTL, 8'h08);
    end
    int_chk(4'hf, 4'he);
    wr(1, qu_pkg::IDX_MODEM_CTL, 8'h00);
    int_sel <= 1'b1;
    int_chk(4'hf, 4'he);
    int_sel <= 1'b0;
    int_chk(4'hd, 4'hc);
    cond[3] <= '0;
    ring_n[3] <= 1'b0;
    wr(3, qu_pkg::IDX_INT_EN, 8'h08);
    int_chk(4'hd, 4'h4);
    ring_n[3] <= 1'b1;
    int_chk(4'hd, 4'hc);
    rd_chk(3, qu_pkg::IDX_MSR, 8'h04);
    int_chk(4'hd, 4'h4);
    check({7'h0, dout_oe}, 8'h00);
    reset_pin_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    check({4'h0, ser_en}, 8'h00);
    check({4'h0, int_oe}, 8'h00);
    check({7'h0, ureset}, 8'h01);
    reset_pin_in <= 1'b0;
    rd_chk(0, 3'h3, 8'h00);
    int_chk(4'h0, 4'h0);
    // The style strap is static, so it only changes under the power-on reset.
    arst_n_in <= 1'b0;
    bus_style_in <= qu_pkg::STYLE_SHARED;
    reset_pin_in <= 1'b1;
    int_sel <= 1'b1;
    cond <= '0;
    repeat (2) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    wr(2, 3'h3, 8'ha5);
    rd_chk(2, 3'h3, 8'ha5);
    rd_chk(1, 3'h3, 8'h00);
    int_chk(4'h0, 4'h0);
    cond[2] <= qu_pkg::qu_cond_type'(4'h1);
    wr(2, qu_pkg::IDX_INT_EN, 8'h01);
    int_chk(4'h1, 4'h0);
    check({7'h0, irq_n}, 8'h00);
    rd_chk(2, qu_pkg::IDX_ISR, 8'h01);
    rd_chk(1, qu_pkg::IDX_ISR, 8'h00);
    reset_pin_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    check({4'h0, ser_en}, 8'h00);
    check({7'h0, ureset}, 8'h01);
    reset_pin_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    check({4'h0, ser_en}, 8'h0f);
    int_chk(4'h0, 4'h0);
    conclude();
  end
endmodule
